// file: verilog/mcp_pkg.sv
package mcp_pkg;

  // framing characters
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_EQ = 8'h3d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_SLASH = 8'h2f;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_K = 8'h4b;

  // command names, two upper-case characters
  localparam logic [15:0] CMD_LINE_RATE = 16'h4252;
  localparam logic [15:0] CMD_FREQ_SLOT = 16'h4348;
  localparam logic [15:0] CMD_TARGET_ID = 16'h4449;
  localparam logic [15:0] CMD_ERROR_FIX = 16'h4543;
  localparam logic [15:0] CMD_OWN_UNIT = 16'h4549;
  localparam logic [15:0] CMD_TEAM_ID = 16'h4749;
  localparam logic [15:0] CMD_FACTORY = 16'h495a;
  localparam logic [15:0] CMD_OP_MODE = 16'h4d44;
  localparam logic [15:0] CMD_PARITY = 16'h5042;
  localparam logic [15:0] CMD_PATH_ATTACH = 16'h5249;
  localparam logic [15:0] CMD_REPLY_VIEW = 16'h524d;
  localparam logic [15:0] CMD_ERROR = 16'h4552;
  localparam logic [15:0] CMD_RELAY_RX = 16'h4443;

  // value codes
  localparam logic [15:0] VAL_CD = 16'h4344;
  localparam logic [15:0] VAL_TX = 16'h5458;
  localparam logic [15:0] VAL_BI = 16'h4249;
  localparam logic [15:0] VAL_NO = 16'h4e4f;
  localparam logic [15:0] VAL_EV = 16'h4556;
  localparam logic [15:0] VAL_OD = 16'h4f44;
  localparam logic [15:0] VAL_OF = 16'h4f46;
  localparam logic [15:0] VAL_ON = 16'h4f4e;
  localparam logic [15:0] VAL_I1 = 16'h4931;
  localparam logic [15:0] VAL_I2 = 16'h4932;
  localparam logic [15:0] VAL_ZERO = 16'h3030;
  localparam logic [15:0] VAL_ERR = 16'h3031;
  localparam logic [15:0] VAL_PERSIST = 16'h2f57;

  // apb byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IDS = 8'h08;

  // status field positions
  localparam int STAT_RATE_POS = 0;
  localparam int STAT_PAR_POS = 4;
  localparam int STAT_FEC_POS = 8;
  localparam int STAT_OPM_POS = 12;
  localparam int STAT_PATH_POS = 16;
  localparam int STAT_RTEXT_POS = 17;
  localparam int STAT_BUSY_POS = 24;

  typedef enum logic [2:0] {
    RATE_1200 = 3'h0, RATE_2400 = 3'h1, RATE_4800 = 3'h2, RATE_9600 = 3'h3,
    RATE_19200 = 3'h4, RATE_38400 = 3'h5, RATE_57600 = 3'h6
  } mcp_rate_type;
  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} mcp_par_type;
  typedef enum logic [1:0] {FEC_OFF = 2'h0, FEC_PLAIN = 2'h1, FEC_IL1 = 2'h2, FEC_IL2 = 2'h3} mcp_fec_type;
  typedef enum logic [1:0] {OPM_CMD = 2'h0, OPM_TEXT = 2'h1, OPM_RAW = 2'h2} mcp_opm_type;
  typedef enum logic [2:0] {P_IDLE = 3'h0, P_N0 = 3'h1, P_N1 = 3'h2, P_VAL = 3'h3, P_LF = 3'h4} mcp_pst_type;
  typedef enum logic [2:0] {
    T_IDLE = 3'h0, T_HEAD = 3'h1, T_DATA = 3'h2, T_SLASH = 3'h3, T_ROUTE = 3'h4, T_CR = 3'h5, T_LF = 3'h6
  } mcp_tst_type;
  typedef enum logic [1:0] {K_RESP = 2'h0, K_ACK = 2'h1, K_DATA = 2'h2} mcp_kind_type;

  // power-on values
  localparam mcp_rate_type RST_RATE = RATE_19200;
  localparam mcp_par_type RST_PAR = PAR_NONE;
  localparam logic [6:0] RST_CHAN = 7'h01;
  localparam logic [7:0] RST_DEST = 8'h01;
  localparam logic [7:0] RST_OWN = 8'h01;
  localparam logic [7:0] RST_TEAM = 8'h00;
  localparam mcp_fec_type RST_FEC = FEC_OFF;
  localparam mcp_opm_type RST_OPM = OPM_CMD;

  localparam logic [6:0] CHAN_MIN = 7'h01;
  localparam logic [7:0] OWN_NONE = 8'hff;
  localparam logic [7:0] DEST_BCAST = 8'h00;
  localparam logic [3:0] HEAD_SHORT = 4'h6;
  localparam logic [3:0] HEAD_TEXT = 4'ha;
  localparam logic [3:0] HEAD_LINE = 4'h8;

  // relay wait before the acknowledgement line
  localparam int RELAY_WAIT_US = 100;
  localparam int CLK_MHZ = 100;

endpackage

// file: verilog/mcp_modem_command_parser.sv
`timescale 1ns/10ps
module mcp_modem_command_parser #(
  parameter int unsigned RELAY_WAIT_CYC = mcp_pkg::RELAY_WAIT_US * mcp_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // host uart bytes
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic RX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // relay data receive event
  input wire logic RELAY_RX_REQ,
  input wire logic [7:0] RELAY_LEVEL,
  input wire logic [7:0] RELAY_SIZE,
  input wire logic RELAY_DATA_VALID,
  input wire logic [7:0] RELAY_DATA,
  output logic RELAY_DATA_READY,
  input wire logic ROUTE_VALID,
  input wire logic [7:0] ROUTE_DATA,
  input wire logic ROUTE_LAST,
  output logic ROUTE_READY,
  // relay acknowledgement event
  input wire logic ACK_REQ,
  input wire logic [7:0] ACK_LEVEL,
  // applied settings
  output logic [2:0] LINE_RATE,
  output logic [1:0] PARITY,
  output logic [6:0] FREQ_SLOT,
  output logic [1:0] ERROR_FIX_MODE,
  output logic CMD_MODE,
  output logic BCAST_EN,
  output logic RX_ACCEPT_EN,
  output logic LEVEL_ONLY,
  output logic NVM_CLEAR
);

  typedef struct packed {
    mcp_pkg::mcp_pst_type pst;
    logic [7:0] n0;
    logic [7:0] n1;
    logic [3:0][7:0] val;
    logic [2:0] vcnt;
    logic exec_pend;
    mcp_pkg::mcp_tst_type tst;
    mcp_pkg::mcp_kind_type kind;
    logic [9:0][7:0] head;
    logic [3:0] hlen;
    logic [3:0] hidx;
    logic [7:0] dcnt;
    logic ovalid;
    logic [7:0] obyte;
    logic apply_pend;
    mcp_pkg::mcp_rate_type rate;
    mcp_pkg::mcp_rate_type rate_new;
    mcp_pkg::mcp_par_type par;
    mcp_pkg::mcp_par_type par_new;
    logic [6:0] chan;
    logic [7:0] dest;
    logic [7:0] own;
    logic [7:0] team;
    mcp_pkg::mcp_fec_type fec;
    mcp_pkg::mcp_opm_type opm;
    logic path;
    logic rtext;
    logic relay_act;
    logic ack_pend;
    logic [7:0] ack_lvl;
    logic [15:0] ack_tmr;
    logic dc_pend;
    logic [7:0] dc_lvl;
    logic [7:0] dc_size;
    logic nvm_clr;
  } mcp_state_type;

  if (RELAY_WAIT_CYC < 1 || RELAY_WAIT_CYC > 65535) begin : g_chk
    $error("RELAY_WAIT_CYC must lie in 1..65535");
  end

  localparam logic [15:0] WAIT_LOAD = 16'(RELAY_WAIT_CYC);

  mcp_state_type s_ff;
  mcp_state_type nxt_s;

  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction

  function automatic logic [4:0] hexval(input logic [7:0] c);
    hexval = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      hexval = {1'b1, c[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      hexval = {1'b1, 4'(c[3:0] + 4'h9)};
    end
  endfunction

  function automatic logic [7:0] hexchr(input logic [3:0] n);
    hexchr = (n < 4'ha) ? {4'h3, n} : {4'h4, 4'(n - 4'h9)};
  endfunction

  function automatic logic [3:0] rate_lookup(input logic [15:0] v);
    case (v)
      16'h3132: rate_lookup = {1'b1, mcp_pkg::RATE_1200};
      16'h3234: rate_lookup = {1'b1, mcp_pkg::RATE_2400};
      16'h3438: rate_lookup = {1'b1, mcp_pkg::RATE_4800};
      16'h3936: rate_lookup = {1'b1, mcp_pkg::RATE_9600};
      16'h3139: rate_lookup = {1'b1, mcp_pkg::RATE_19200};
      16'h3338: rate_lookup = {1'b1, mcp_pkg::RATE_38400};
      16'h3537: rate_lookup = {1'b1, mcp_pkg::RATE_57600};
      default: rate_lookup = 4'h0;
    endcase
  endfunction

  logic can_load;
  logic [7:0] c;
  logic [15:0] name;
  logic [15:0] vpair;
  logic [4:0] hx_hi;
  logic [4:0] hx_lo;
  logic [7:0] hbyte;
  logic hex_ok;
  logic two;
  logic ok;
  logic [3:0] rl;
  logic after_data_route;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.nvm_clr = 1'b0;
    can_load = !s_ff.ovalid || TX_READY;
    c = upcase(RX_DATA);
    name = {s_ff.n0, s_ff.n1};
    vpair = {s_ff.val[0], s_ff.val[1]};
    hx_hi = hexval(s_ff.val[0]);
    hx_lo = hexval(s_ff.val[1]);
    hbyte = {hx_hi[3:0], hx_lo[3:0]};
    two = s_ff.vcnt == 3'h2;
    hex_ok = two && hx_hi[4] && hx_lo[4];
    ok = 1'b0;
    rl = rate_lookup(vpair);
    after_data_route = s_ff.path;
    if (s_ff.ovalid && TX_READY) begin
      nxt_s.ovalid = 1'b0;
    end
    // apb control writes
    if (PSEL && PENABLE && PWRITE && PADDR == mcp_pkg::ADDR_CTRL) begin
      nxt_s.relay_act = PWDATA[0];
      if (PWDATA[1]) begin
        nxt_s.opm = mcp_pkg::OPM_CMD;
      end
    end
    // parser; bytes outside command mode are not commands
    if (RX_VALID && !s_ff.exec_pend && s_ff.opm == mcp_pkg::OPM_CMD) begin
      if (RX_DATA == mcp_pkg::CH_AT) begin
        nxt_s.pst = mcp_pkg::P_N0;
        nxt_s.vcnt = 3'h0;
      end else begin
        case (s_ff.pst)
          mcp_pkg::P_N0: begin
            nxt_s.n0 = c;
            nxt_s.pst = mcp_pkg::P_N1;
          end
          mcp_pkg::P_N1: begin
            nxt_s.n1 = c;
            nxt_s.pst = mcp_pkg::P_VAL;
          end
          mcp_pkg::P_VAL: begin
            if (RX_DATA == mcp_pkg::CH_CR) begin
              nxt_s.pst = mcp_pkg::P_LF;
            end else if (RX_DATA != mcp_pkg::CH_SP) begin
              if (s_ff.vcnt < 3'h4) begin
                nxt_s.val[s_ff.vcnt[1:0]] = c;
                nxt_s.vcnt = s_ff.vcnt + 3'h1;
              end else begin
                nxt_s.pst = mcp_pkg::P_IDLE;
              end
            end
          end
          mcp_pkg::P_LF: begin
            nxt_s.exec_pend = RX_DATA == mcp_pkg::CH_LF;
            nxt_s.pst = mcp_pkg::P_IDLE;
          end
          default: nxt_s.pst = mcp_pkg::P_IDLE;
        endcase
      end
    end
    // launch a line or apply deferred uart settings
    if (s_ff.tst == mcp_pkg::T_IDLE) begin
      nxt_s.hidx = 4'h0;
      if (s_ff.exec_pend) begin
        nxt_s.exec_pend = 1'b0;
        case (name)
          mcp_pkg::CMD_LINE_RATE: begin
            ok = two && rl[3];
            if (ok) begin
              nxt_s.rate_new = mcp_pkg::mcp_rate_type'(rl[2:0]);
              nxt_s.apply_pend = 1'b1;
            end
          end
          mcp_pkg::CMD_PARITY: begin
            ok = two && (vpair == mcp_pkg::VAL_NO || vpair == mcp_pkg::VAL_EV || vpair == mcp_pkg::VAL_OD);
            if (ok) begin
              nxt_s.par_new = (vpair == mcp_pkg::VAL_EV) ? mcp_pkg::PAR_EVEN :
                (vpair == mcp_pkg::VAL_OD) ? mcp_pkg::PAR_ODD : mcp_pkg::PAR_NONE;
              nxt_s.apply_pend = 1'b1;
            end
          end
          mcp_pkg::CMD_FREQ_SLOT: begin
            ok = hex_ok && !hbyte[7] && hbyte[6:0] >= mcp_pkg::CHAN_MIN;
            if (ok) begin
              nxt_s.chan = hbyte[6:0];
            end
          end
          mcp_pkg::CMD_TARGET_ID: begin
            ok = hex_ok;
            if (ok) begin
              nxt_s.dest = hbyte;
            end
          end
          mcp_pkg::CMD_OWN_UNIT: begin
            ok = hex_ok && hbyte != 8'h00;
            if (ok) begin
              nxt_s.own = hbyte;
            end
          end
          mcp_pkg::CMD_TEAM_ID: begin
            ok = hex_ok;
            if (ok) begin
              nxt_s.team = hbyte;
            end
          end
          mcp_pkg::CMD_OP_MODE: begin
            ok = two && (vpair == mcp_pkg::VAL_CD || vpair == mcp_pkg::VAL_TX || vpair == mcp_pkg::VAL_BI);
            if (ok) begin
              nxt_s.opm = (vpair == mcp_pkg::VAL_TX) ? mcp_pkg::OPM_TEXT :
                (vpair == mcp_pkg::VAL_BI) ? mcp_pkg::OPM_RAW : mcp_pkg::OPM_CMD;
            end
          end
          mcp_pkg::CMD_PATH_ATTACH: begin
            ok = two && (vpair == mcp_pkg::VAL_ON || vpair == mcp_pkg::VAL_OF);
            if (ok) begin
              nxt_s.path = vpair == mcp_pkg::VAL_ON;
            end
          end
          mcp_pkg::CMD_REPLY_VIEW: begin
            ok = two && (vpair == mcp_pkg::VAL_CD || vpair == mcp_pkg::VAL_TX);
            if (ok) begin
              nxt_s.rtext = vpair == mcp_pkg::VAL_TX;
            end
          end
          mcp_pkg::CMD_ERROR_FIX, mcp_pkg::CMD_FACTORY: begin
            if (name == mcp_pkg::CMD_FACTORY) begin
              ok = s_ff.vcnt == 3'h0;
            end else begin
              ok = s_ff.vcnt == 3'h4 && {s_ff.val[2], s_ff.val[3]} == mcp_pkg::VAL_PERSIST &&
                (vpair == mcp_pkg::VAL_OF || vpair == mcp_pkg::VAL_ON ||
                 vpair == mcp_pkg::VAL_I1 || vpair == mcp_pkg::VAL_I2);
            end
            if (ok) begin
              nxt_s.chan = mcp_pkg::RST_CHAN;
              nxt_s.dest = mcp_pkg::RST_DEST;
              nxt_s.own = mcp_pkg::RST_OWN;
              nxt_s.team = mcp_pkg::RST_TEAM;
              nxt_s.opm = mcp_pkg::RST_OPM;
              nxt_s.path = 1'b0;
              nxt_s.rtext = 1'b0;
              nxt_s.rate_new = mcp_pkg::RST_RATE;
              nxt_s.par_new = mcp_pkg::RST_PAR;
              nxt_s.apply_pend = 1'b1;
              if (name == mcp_pkg::CMD_FACTORY) begin
                nxt_s.fec = mcp_pkg::RST_FEC;
                nxt_s.nvm_clr = 1'b1;
              end else begin
                nxt_s.fec = (vpair == mcp_pkg::VAL_ON) ? mcp_pkg::FEC_PLAIN :
                  (vpair == mcp_pkg::VAL_I1) ? mcp_pkg::FEC_IL1 :
                  (vpair == mcp_pkg::VAL_I2) ? mcp_pkg::FEC_IL2 : mcp_pkg::FEC_OFF;
              end
            end
          end
          default: ok = 1'b0;
        endcase
        // response header, optional text tail
        nxt_s.head[0] = mcp_pkg::CH_STAR;
        {nxt_s.head[1], nxt_s.head[2]} = ok ? name : mcp_pkg::CMD_ERROR;
        nxt_s.head[3] = mcp_pkg::CH_EQ;
        {nxt_s.head[4], nxt_s.head[5]} = !ok ? mcp_pkg::VAL_ERR :
          (name == mcp_pkg::CMD_FACTORY) ? mcp_pkg::VAL_ZERO : vpair;
        nxt_s.head[6] = mcp_pkg::CH_SP;
        nxt_s.head[7] = mcp_pkg::CH_COLON;
        nxt_s.head[8] = mcp_pkg::CH_O;
        nxt_s.head[9] = mcp_pkg::CH_K;
        nxt_s.hlen = s_ff.rtext ? mcp_pkg::HEAD_TEXT : mcp_pkg::HEAD_SHORT;
        nxt_s.kind = mcp_pkg::K_RESP;
        nxt_s.tst = mcp_pkg::T_HEAD;
      end else if ((s_ff.ack_pend && s_ff.ack_tmr == 16'h0000) || s_ff.dc_pend) begin
        // relay lines: prefix, level, then 00 or size
        nxt_s.head[0] = mcp_pkg::CH_STAR;
        {nxt_s.head[1], nxt_s.head[2]} = mcp_pkg::CMD_RELAY_RX;
        nxt_s.head[3] = mcp_pkg::CH_EQ;
        nxt_s.hlen = mcp_pkg::HEAD_LINE;
        nxt_s.tst = mcp_pkg::T_HEAD;
        if (s_ff.ack_pend && s_ff.ack_tmr == 16'h0000) begin
          nxt_s.head[4] = hexchr(s_ff.ack_lvl[7:4]);
          nxt_s.head[5] = hexchr(s_ff.ack_lvl[3:0]);
          {nxt_s.head[6], nxt_s.head[7]} = mcp_pkg::VAL_ZERO;
          nxt_s.kind = mcp_pkg::K_ACK;
          nxt_s.ack_pend = 1'b0;
        end else begin
          nxt_s.head[4] = hexchr(s_ff.dc_lvl[7:4]);
          nxt_s.head[5] = hexchr(s_ff.dc_lvl[3:0]);
          nxt_s.head[6] = hexchr(s_ff.dc_size[7:4]);
          nxt_s.head[7] = hexchr(s_ff.dc_size[3:0]);
          nxt_s.dcnt = s_ff.dc_size;
          nxt_s.kind = mcp_pkg::K_DATA;
          nxt_s.dc_pend = 1'b0;
        end
      end else if (s_ff.apply_pend && !s_ff.ovalid) begin
        nxt_s.rate = s_ff.rate_new;
        nxt_s.par = s_ff.par_new;
        nxt_s.apply_pend = 1'b0;
      end
    end
    // byte emitter into the output holding register
    if (can_load) begin
      case (s_ff.tst)
        mcp_pkg::T_HEAD: begin
          nxt_s.obyte = s_ff.head[s_ff.hidx];
          nxt_s.ovalid = 1'b1;
          nxt_s.hidx = s_ff.hidx + 4'h1;
          if (s_ff.hidx == s_ff.hlen - 4'h1) begin
            if (s_ff.kind != mcp_pkg::K_DATA) begin
              nxt_s.tst = mcp_pkg::T_CR;
            end else if (s_ff.dcnt != 8'h00) begin
              nxt_s.tst = mcp_pkg::T_DATA;
            end else begin
              nxt_s.tst = after_data_route ? mcp_pkg::T_SLASH : mcp_pkg::T_CR;
            end
          end
        end
        mcp_pkg::T_DATA: begin
          if (RELAY_DATA_VALID) begin
            nxt_s.obyte = RELAY_DATA;
            nxt_s.ovalid = 1'b1;
            nxt_s.dcnt = s_ff.dcnt - 8'h01;
            if (s_ff.dcnt == 8'h01) begin
              nxt_s.tst = after_data_route ? mcp_pkg::T_SLASH : mcp_pkg::T_CR;
            end
          end
        end
        mcp_pkg::T_SLASH: begin
          nxt_s.obyte = mcp_pkg::CH_SLASH;
          nxt_s.ovalid = 1'b1;
          nxt_s.tst = mcp_pkg::T_ROUTE;
        end
        mcp_pkg::T_ROUTE: begin
          if (ROUTE_VALID) begin
            nxt_s.obyte = ROUTE_DATA;
            nxt_s.ovalid = 1'b1;
            if (ROUTE_LAST) begin
              nxt_s.tst = mcp_pkg::T_CR;
            end
          end
        end
        mcp_pkg::T_CR: begin
          nxt_s.obyte = mcp_pkg::CH_CR;
          nxt_s.ovalid = 1'b1;
          nxt_s.tst = mcp_pkg::T_LF;
        end
        mcp_pkg::T_LF: begin
          nxt_s.obyte = mcp_pkg::CH_LF;
          nxt_s.ovalid = 1'b1;
          nxt_s.tst = mcp_pkg::T_IDLE;
        end
        mcp_pkg::T_IDLE: begin
          // launch decided above, keep its state
          nxt_s.obyte = s_ff.obyte;
        end
        default: nxt_s.tst = mcp_pkg::T_IDLE;
      endcase
    end
    // event capture last so a new event beats its own clear
    if (s_ff.ack_pend && s_ff.ack_tmr != 16'h0000) begin
      nxt_s.ack_tmr = s_ff.ack_tmr - 16'h0001;
    end
    if (ACK_REQ) begin
      nxt_s.ack_pend = 1'b1;
      nxt_s.ack_lvl = ACK_LEVEL;
      nxt_s.ack_tmr = WAIT_LOAD - 16'h0001;
    end
    if (RELAY_RX_REQ) begin
      nxt_s.dc_pend = 1'b1;
      nxt_s.dc_lvl = RELAY_LEVEL;
      nxt_s.dc_size = RELAY_SIZE;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s_ff <= '0;
      s_ff.rate <= mcp_pkg::RST_RATE;
      s_ff.rate_new <= mcp_pkg::RST_RATE;
      s_ff.chan <= mcp_pkg::RST_CHAN;
      s_ff.dest <= mcp_pkg::RST_DEST;
      s_ff.own <= mcp_pkg::RST_OWN;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // apb read side, zero-wait
  always_comb begin
    PRDATA = 32'h0000_0000;
    PSLVERR = 1'b0;
    case (PADDR)
      mcp_pkg::ADDR_CTRL: PRDATA[0] = s_ff.relay_act;
      mcp_pkg::ADDR_STAT: begin
        PRDATA[mcp_pkg::STAT_RATE_POS +: 3] = s_ff.rate;
        PRDATA[mcp_pkg::STAT_PAR_POS +: 2] = s_ff.par;
        PRDATA[mcp_pkg::STAT_FEC_POS +: 2] = s_ff.fec;
        PRDATA[mcp_pkg::STAT_OPM_POS +: 2] = s_ff.opm;
        PRDATA[mcp_pkg::STAT_PATH_POS] = s_ff.path;
        PRDATA[mcp_pkg::STAT_RTEXT_POS] = s_ff.rtext;
        PRDATA[mcp_pkg::STAT_BUSY_POS] = s_ff.tst != mcp_pkg::T_IDLE;
      end
      mcp_pkg::ADDR_IDS: PRDATA = {1'b0, s_ff.chan, s_ff.team, s_ff.own, s_ff.dest};
      default: PSLVERR = PSEL && PENABLE;
    endcase
    if (!(PSEL && PENABLE && !PWRITE)) begin
      PRDATA = 32'h0000_0000;
    end
  end

  assign PREADY = 1'b1;
  assign RX_READY = !s_ff.exec_pend;
  assign TX_VALID = s_ff.ovalid;
  assign TX_DATA = s_ff.obyte;
  assign RELAY_DATA_READY = s_ff.tst == mcp_pkg::T_DATA && can_load;
  assign ROUTE_READY = s_ff.tst == mcp_pkg::T_ROUTE && can_load;
  assign LINE_RATE = s_ff.rate;
  assign PARITY = s_ff.par;
  assign FREQ_SLOT = s_ff.chan;
  assign ERROR_FIX_MODE = s_ff.fec;
  assign CMD_MODE = s_ff.opm == mcp_pkg::OPM_CMD;
  assign BCAST_EN = s_ff.dest == mcp_pkg::DEST_BCAST && !s_ff.relay_act;
  assign RX_ACCEPT_EN = s_ff.own != mcp_pkg::OWN_NONE;
  assign LEVEL_ONLY = s_ff.own == mcp_pkg::OWN_NONE;
  assign NVM_CLEAR = s_ff.nvm_clr;

endmodule

// file: verif/mcp_monitor.sv
`timescale 1ns/10ps
module mcp_monitor (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // host line
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // settings
  input wire logic [2:0] LINE_RATE,
  input wire logic [1:0] PARITY,
  input wire logic [6:0] FREQ_SLOT,
  input wire logic LEVEL_ONLY,
  input wire logic RX_ACCEPT_EN,
  input wire logic NVM_CLEAR
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_cr_taken;
    TX_VALID && TX_READY && TX_DATA == 8'h0d;
  endsequence
  sequence s_lf_shown;
    TX_VALID && TX_DATA == 8'h0a;
  endsequence
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA)) else $error("tx byte lost");
  a_line_head: assert property ($rose(TX_VALID) |-> TX_DATA == 8'h2a) else $error("line not starred");
  a_cr_lf: assert property (s_cr_taken |=> s_lf_shown) else $error("cr without lf");
  a_rate_idle: assert property (!$stable(LINE_RATE) |-> !$past(TX_VALID)) else $error("rate moved in line");
  a_par_idle: assert property (!$stable(PARITY) |-> !$past(TX_VALID)) else $error("parity moved in line");
  a_rate_code: assert property (LINE_RATE <= 3'h6) else $error("bad rate code");
  a_par_code: assert property (PARITY != 2'h3) else $error("bad parity code");
  a_slot_min: assert property (FREQ_SLOT != 7'h00) else $error("slot zero");
  a_level_only: assert property (LEVEL_ONLY != RX_ACCEPT_EN) else $error("own id modes clash");
  a_nvm_pulse: assert property (NVM_CLEAR |=> !NVM_CLEAR) else $error("nvm clear stuck");
endmodule

// file: verif/mcp_host_model.sv
`timescale 1ns/10ps
module mcp_host_model (
  // uart bytes
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic slow = 1'h0;
  int lost = 0;
  initial begin
    rx_valid = 1'h0;
    rx_data = 8'h00;
    tx_ready = 1'h0;
  end
  // byte level link: new rate and parity follow at once
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= slow ? !tx_ready : 1'h1;
  end
  // at-sign framed, cr lf closed
  task automatic send(input string s);
    string t;
    t = {s, "\015\012"};
    for (int i = 0; i < t.len(); i++) begin
      rx_valid <= 1'h1;
      rx_data <= t[i];
      for (int j = 0; j < 50; j++) begin
        @(negedge clk);
        if (rx_ready) break;
        if (j == 49) lost++;
      end
      @(posedge clk);
    end
    rx_valid <= 1'h0;
    rx_data <= ~rx_data;
  endtask
endmodule

// file: verif/mcp_modem_command_parser_tb.sv
`timescale 1ns/10ps
module mcp_modem_command_parser_tb;
  logic CLOCK = 1'h0, RSTN = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, PREADY, PSLVERR;
  logic [7:0] PADDR = 8'h00, RX_DATA, TX_DATA, RELAY_DATA = 8'h41, ROUTE_DATA = 8'h52;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic RX_VALID, RX_READY, TX_VALID, TX_READY, RELAY_DATA_READY, ROUTE_READY, err;
  logic RELAY_RX_REQ = 1'h0, ACK_REQ = 1'h0, RELAY_DATA_VALID = 1'h1, ROUTE_VALID = 1'h1, ROUTE_LAST = 1'h1;
  logic [7:0] RELAY_LEVEL = 8'h00, RELAY_SIZE = 8'h00, ACK_LEVEL = 8'h00;
  logic [2:0] LINE_RATE;
  logic [1:0] PARITY, ERROR_FIX_MODE;
  logic [6:0] FREQ_SLOT;
  logic CMD_MODE, BCAST_EN, RX_ACCEPT_EN, LEVEL_ONLY, NVM_CLEAR, nvm_seen = 1'h0;
  int miscompares = 0, n_tests = 0, n_pull = 0, n_route = 0;
  mcp_modem_command_parser #(.RELAY_WAIT_CYC(8)) dut (.*);
  mcp_host_model h (.clk(CLOCK), .rx_valid(RX_VALID), .rx_data(RX_DATA), .rx_ready(RX_READY),
    .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_ready(TX_READY));
  always #5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (NVM_CLEAR === 1'h1) nvm_seen <= 1'h1;
  always @(posedge CLOCK) begin
    if (RELAY_DATA_READY === 1'h1) n_pull <= n_pull + 1;
    if (ROUTE_READY === 1'h1) n_route <= n_route + 1;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic timeout;
    chk("wait bound", 32'h0, 32'h1);
    finish_test();
  endtask
  task automatic line(input string s);
    string t;
    t = {s, "\015\012"};
    for (int i = 0; h.got.size() < t.len(); i++) begin
      if (i == 400) timeout();
      @(posedge CLOCK);
    end
    foreach (h.got[i]) chk("tx byte", h.got[i], t[i]);
    h.got.delete();
    repeat (3) @(posedge CLOCK);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'h1;
    for (int i = 0; i < 10; i++) begin
      @(posedge CLOCK);
      if (PREADY === 1'h1) break;
      if (i == 9) timeout();
    end
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CLOCK);
  endtask
  task automatic t_reset;
    chk("rate", LINE_RATE, 3'h4);
    chk("parity", PARITY, 2'h0);
    chk("fec", ERROR_FIX_MODE, 2'h0);
    apb(1'h0, 8'h08, 32'h0);
    chk("ids", q, 32'h01000101);
    $display("test reset done");
  endtask
  task automatic t_cmd;
    h.send("@CH1@ch 0F");
    line("*CH=0F");
    chk("slot", FREQ_SLOT, 7'h0f);
    h.send("@br57");
    line("*BR=57");
    chk("rate", LINE_RATE, 3'h6);
    h.send("@PBod");
    line("*PB=OD");
    chk("parity", PARITY, 2'h2);
    h.send("@ECI2/W");
    line("*EC=I2");
    chk("fec", ERROR_FIX_MODE, 2'h3);
    chk("slot", FREQ_SLOT, 7'h01);
    chk("rate", LINE_RATE, 3'h4);
    apb(1'h0, 8'h04, 32'h0);
    chk("stat", q, 32'h00000304);
    h.send("@EIff");
    line("*EI=FF");
    chk("level", LEVEL_ONLY, 1'h1);
    chk("accept", RX_ACCEPT_EN, 1'h0);
    h.send("@IZ");
    line("*IZ=00");
    chk("nvm", nvm_seen, 1'h1);
    chk("fec", ERROR_FIX_MODE, 2'h0);
    h.send("@SR");
    line("*ER=01");
    $display("test cmd done");
  endtask
  task automatic t_mode;
    h.send("@RMtx");
    line("*RM=TX");
    h.send("@GI34");
    line("*GI=34 :OK");
    h.send("@RMCD");
    line("*RM=CD :OK");
    h.send("@DI00");
    line("*DI=00");
    chk("bcast", BCAST_EN, 1'h1);
    apb(1'h0, 8'h08, 32'h0);
    chk("ids", q, 32'h01340100);
    apb(1'h1, 8'h00, 32'h1);
    chk("bcast", BCAST_EN, 1'h0);
    h.send("@MDBI");
    line("*MD=BI");
    chk("cmd", CMD_MODE, 1'h0);
    h.send("@CH05");
    repeat (20) @(posedge CLOCK);
    chk("ignored", h.got.size(), 32'h0);
    chk("slot kept", FREQ_SLOT, 7'h01);
    apb(1'h1, 8'h00, 32'h2);
    chk("cmd", CMD_MODE, 1'h1);
    apb(1'h0, 8'h40, 32'h0);
    chk("slverr", err, 1'h1);
    $display("test mode done");
  endtask
  task automatic t_relay;
    h.slow <= 1'h1;
    ACK_REQ <= 1'h1;
    ACK_LEVEL <= 8'h55;
    @(posedge CLOCK);
    ACK_REQ <= 1'h0;
    repeat (6) @(posedge CLOCK);
    chk("early ack", h.got.size(), 32'h0);
    line("*DC=5500");
    h.send("@RION");
    line("*RI=ON");
    RELAY_RX_REQ <= 1'h1;
    RELAY_LEVEL <= 8'h45;
    RELAY_SIZE <= 8'h02;
    @(posedge CLOCK);
    RELAY_RX_REQ <= 1'h0;
    line("*DC=4502AA/R");
    chk("data pulls", n_pull, 32'h2);
    chk("route pulls", n_route, 32'h1);
    chk("lost bytes", h.lost, 32'h0);
    $display("test relay done");
  endtask
  initial begin
    repeat (3) @(posedge CLOCK);
    RSTN <= 1'h1;
    @(posedge CLOCK);
    t_reset();
    t_cmd();
    t_mode();
    t_relay();
    finish_test();
  end
endmodule
bind mcp_modem_command_parser mcp_monitor mon (.CLOCK(CLOCK), .RSTN(RSTN), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
  .TX_READY(TX_READY), .LINE_RATE(LINE_RATE), .PARITY(PARITY), .FREQ_SLOT(FREQ_SLOT), .LEVEL_ONLY(LEVEL_ONLY),
  .RX_ACCEPT_EN(RX_ACCEPT_EN), .NVM_CLEAR(NVM_CLEAR));
